// *** rtl/tmr_regs.vh ***
// Purpose: register offsets, fields, reset values and codes for the 8-bit timer block
// Assumes: byte-wide registers on a plain strobe port
// Notes: offsets are local to this block
`ifndef TMR_REGS_VH
`define TMR_REGS_VH
`define TMR_ADDR_W 3
`define TMR_OFS_CONTROL_A 3'h0
`define TMR_OFS_CONTROL_B 3'h1
`define TMR_OFS_COUNT 3'h2
`define TMR_OFS_COMPARE_A 3'h3
`define TMR_OFS_COMPARE_B 3'h4
`define TMR_OFS_IRQ_MASK 3'h5
`define TMR_OFS_IRQ_FLAGS 3'h6
`define TMR_OFS_IRQ_ACK 3'h7
`define TMR_BIT_FORCE_A 7
`define TMR_BIT_FORCE_B 6
`define TMR_BIT_WGM2 3
`define TMR_BIT_FLAG_B 2
`define TMR_BIT_FLAG_A 1
`define TMR_BIT_FLAG_OVF 0
`define TMR_RESET_BYTE 8'h00
`define TMR_MAX 8'hFF
`define TMR_BOTTOM 8'h00
`define TMR_DIV8 10'h007
`define TMR_DIV64 10'h03F
`define TMR_DIV256 10'h0FF
`define TMR_DIV1024 10'h3FF
`define TMR_CS_STOP 3'h0
`define TMR_CS_DIV1 3'h1
`define TMR_CS_DIV8 3'h2
`define TMR_CS_DIV64 3'h3
`define TMR_CS_DIV256 3'h4
`define TMR_CS_DIV1024 3'h5
`define TMR_CS_EXT_FALL 3'h6
`define TMR_CS_EXT_RISE 3'h7
`define TMR_WGM_NORMAL 3'h0
`define TMR_WGM_PC_FF 3'h1
`define TMR_WGM_CTC 3'h2
`define TMR_WGM_FAST_FF 3'h3
`define TMR_WGM_PC_OCA 3'h5
`define TMR_WGM_FAST_OCA 3'h7
`define TMR_COM_OFF 2'h0
`define TMR_COM_TOGGLE 2'h1
`define TMR_COM_CLEAR 2'h2
`define TMR_COM_SET 2'h3
`endif

// *** rtl/tmr_timer8.v ***
// Purpose: 8-bit timer/counter with control, counter, compare and interrupt registers
// Assumes: one 20 MHz clock; external count pin is asynchronous
// Notes: no interrupt controller here; irq request outputs go to the processor core
//
// Chosen here: the address-and-strobe port and the register offsets.
`include "tmr_regs.vh"
module tmr_timer8 #(
  parameter PRESCALE_W = 10
) (
  input wire clk_in,
  input wire reset_n_in,
  input wire [2:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire global_irq_enable_in,
  input wire [2:0] vector_ack_in,
  input wire external_count_pin_in,
  output reg [7:0] rdata_out,
  output reg compare_output_a_out,
  output reg compare_output_b_out,
  output reg compare_output_a_en_out,
  output reg compare_output_b_en_out,
  output reg [2:0] irq_request_out
);
  // ****************************************
  // registers
  // ****************************************
  reg [7:0] control_a;
  reg waveform_mode_bit2;
  reg [2:0] clock_select;
  reg [7:0] timer_count_value;
  reg [7:0] compare_value_a;
  reg [7:0] compare_value_b;
  reg [2:0] timer_interrupt_mask;
  reg [2:0] timer_interrupt_flags;
  reg [PRESCALE_W-1:0] prescale;
  reg ext_sync1;
  reg ext_sync2;
  reg ext_last;
  reg count_down;
  reg block_match;
  reg [7:0] ocr_a_buf;
  reg [7:0] ocr_b_buf;
  wire [2:0] wgm;
  wire [1:0] output_mode_a;
  wire [1:0] output_mode_b;
  wire pwm_mode;
  wire phase_mode;
  wire oca_top;
  wire [7:0] top_value;
  wire [7:0] cmp_a;
  wire [7:0] cmp_b;
  wire wr_count;
  wire force_a;
  wire force_b;
  reg tick;
  wire at_top;
  wire match_a;
  wire match_b;
  wire overflow;
  wire [2:0] flag_clear;
  wire [2:0] flag_set;
  wire wr_ctrl_a;
  wire wr_ctrl_b;
  wire wr_cmp_a;
  wire wr_cmp_b;
  wire wr_mask;
  wire wr_flags;
  wire ext_rise;
  wire ext_fall;
  wire hold_a;
  wire hold_b;
  reg [7:0] rd_word;

  // ****************************************
  // bus decode
  // ****************************************
  // one decoder for every register strobe
  function reg_hit;
    input strobe;
    input [2:0] addr;
    input [2:0] ofs;
    begin
      reg_hit = strobe && (addr == ofs);
    end
  endfunction

  // divided tick when all masked prescaler bits are ones
  function div_hit;
    input [PRESCALE_W-1:0] count;
    input [PRESCALE_W-1:0] mask;
    begin
      div_hit = ((count & mask) == mask);
    end
  endfunction

  assign wr_ctrl_a = reg_hit(wr_in, addr_in, `TMR_OFS_CONTROL_A);
  assign wr_ctrl_b = reg_hit(wr_in, addr_in, `TMR_OFS_CONTROL_B);
  assign wr_cmp_a = reg_hit(wr_in, addr_in, `TMR_OFS_COMPARE_A);
  assign wr_cmp_b = reg_hit(wr_in, addr_in, `TMR_OFS_COMPARE_B);
  assign wr_mask = reg_hit(wr_in, addr_in, `TMR_OFS_IRQ_MASK);
  assign wr_flags = reg_hit(wr_in, addr_in, `TMR_OFS_IRQ_FLAGS);
  assign ext_rise = ext_sync2 && !ext_last;
  assign ext_fall = !ext_sync2 && ext_last;
  // compare equal to top in fast pwm: only the top restore sets the level
  assign hold_a = pwm_mode && !phase_mode && output_mode_a[1] && (cmp_a == top_value);
  assign hold_b = pwm_mode && !phase_mode && output_mode_b[1] && (cmp_b == top_value);

  assign wgm = {waveform_mode_bit2, control_a[1:0]};
  assign output_mode_a = control_a[7:6];
  assign output_mode_b = control_a[5:4];
  assign pwm_mode = control_a[0];
  assign phase_mode = (wgm == `TMR_WGM_PC_FF) || (wgm == `TMR_WGM_PC_OCA);
  assign oca_top = waveform_mode_bit2 || (wgm == `TMR_WGM_CTC);
  assign top_value = oca_top ? cmp_a : `TMR_MAX;
  // pwm modes use the copy latched at top so edits cannot glitch a period
  assign cmp_a = pwm_mode ? ocr_a_buf : compare_value_a;
  assign cmp_b = pwm_mode ? ocr_b_buf : compare_value_b;
  assign wr_count = reg_hit(wr_in, addr_in, `TMR_OFS_COUNT);
  // one-cycle strobes from the write itself, nothing stored
  assign force_a = wr_ctrl_b && wdata_in[`TMR_BIT_FORCE_A]
    && !pwm_mode;
  assign force_b = wr_ctrl_b && wdata_in[`TMR_BIT_FORCE_B]
    && !pwm_mode;
  assign at_top = (timer_count_value == top_value);
  assign match_a = tick && !block_match && (timer_count_value == cmp_a);
  assign match_b = tick && !block_match && (timer_count_value == cmp_b);
  // flag timing follows waveform mode
  assign overflow = tick && (phase_mode ? (timer_count_value == `TMR_BOTTOM && count_down) :
    (wgm == `TMR_WGM_FAST_OCA) ? at_top : (timer_count_value == `TMR_MAX));
  assign flag_clear = vector_ack_in | (wr_flags ? wdata_in[2:0] : 3'h0);
  assign flag_set = {match_b, match_a, overflow};

  // ****************************************
  // clock select
  // ****************************************
  // pin read only through the synchroniser, so the output driver never matters
  always @* begin
    case (clock_select)
      `TMR_CS_STOP: tick = 1'b0;
      `TMR_CS_DIV1: tick = 1'b1;
      `TMR_CS_DIV8: tick = div_hit(prescale, `TMR_DIV8);
      `TMR_CS_DIV64: tick = div_hit(prescale, `TMR_DIV64);
      `TMR_CS_DIV256: tick = div_hit(prescale, `TMR_DIV256);
      `TMR_CS_DIV1024: tick = div_hit(prescale, `TMR_DIV1024);
      `TMR_CS_EXT_FALL: tick = ext_fall;
      `TMR_CS_EXT_RISE: tick = ext_rise;
      default: tick = 1'b0;
    endcase
  end

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prescale <= {PRESCALE_W{1'b0}};
    end else begin
      prescale <= prescale + 1'b1;
    end
  end

  // two flops before use; pin direction does not matter here
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ext_sync1 <= 1'b0;
      ext_sync2 <= 1'b0;
      ext_last <= 1'b0;
    end else begin
      ext_sync1 <= external_count_pin_in;
      ext_sync2 <= ext_sync1;
      ext_last <= ext_sync2;
    end
  end

  // ****************************************
  // software registers
  // ****************************************
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      control_a <= `TMR_RESET_BYTE;
      waveform_mode_bit2 <= 1'b0;
      clock_select <= `TMR_CS_STOP;
    end else begin
      // bits 3:2 of control a are reserved and stay zero
      if (wr_ctrl_a) begin
        control_a <= {wdata_in[7:4], 2'h0, wdata_in[1:0]};
      end
      // force bits are decoded as strobes only, never stored
      if (wr_ctrl_b) begin
        waveform_mode_bit2 <= wdata_in[`TMR_BIT_WGM2];
        clock_select <= wdata_in[2:0];
      end
    end
  end

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      compare_value_a <= `TMR_RESET_BYTE;
      compare_value_b <= `TMR_RESET_BYTE;
    end else begin
      if (wr_cmp_a) begin
        compare_value_a <= wdata_in;
      end
      if (wr_cmp_b) begin
        compare_value_b <= wdata_in;
      end
    end
  end

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      timer_interrupt_mask <= 3'h0;
    end else if (wr_mask) begin
      timer_interrupt_mask <= wdata_in[2:0];
    end
  end

  // ****************************************
  // counter
  // ****************************************
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      timer_count_value <= `TMR_RESET_BYTE;
      ocr_a_buf <= `TMR_RESET_BYTE;
      ocr_b_buf <= `TMR_RESET_BYTE;
      count_down <= 1'b0;
      block_match <= 1'b0;
    end else begin
      // held until a tick has passed after the write
      if (wr_count) begin
        block_match <= 1'b1;
      end else if (tick) begin
        block_match <= 1'b0;
      end
      if (wr_count) begin
        timer_count_value <= wdata_in;
      end else if (tick) begin
        // forced matches never reach this path, so no clear from a strobe
        if (phase_mode) begin
          if (!count_down && at_top) begin
            count_down <= 1'b1;
            timer_count_value <= timer_count_value - 1'b1;
          end else if (count_down && timer_count_value == `TMR_BOTTOM) begin
            count_down <= 1'b0;
            timer_count_value <= timer_count_value + 1'b1;
          end else begin
            timer_count_value <= count_down ? timer_count_value - 1'b1 : timer_count_value + 1'b1;
          end
        end else if (at_top) begin
          count_down <= 1'b0;
          timer_count_value <= `TMR_BOTTOM;
        end else begin
          count_down <= 1'b0;
          timer_count_value <= timer_count_value + 1'b1;
        end
        if (at_top) begin
          ocr_a_buf <= compare_value_a;
          ocr_b_buf <= compare_value_b;
        end
      end
    end
  end

  // ****************************************
  // flags
  // ****************************************
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      timer_interrupt_flags <= 3'h0;
    end else begin
      // a hardware set in the same cycle beats the clear
      timer_interrupt_flags <= (timer_interrupt_flags & ~flag_clear)
        | flag_set;
    end
  end

  // ****************************************
  // waveform outputs
  // ****************************************
  function out_next;
    input [1:0] mode;
    input cur;
    input pwm;
    input up;
    begin
      case (mode)
        `TMR_COM_TOGGLE: out_next = pwm ? cur : !cur;
        `TMR_COM_CLEAR: out_next = pwm ? !up : 1'b0;
        `TMR_COM_SET: out_next = pwm ? up : 1'b1;
        default: out_next = cur;
      endcase
    end
  endfunction

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      compare_output_a_out <= 1'b0;
    end else begin
      // fast pwm: restore level at top; phase-correct uses count direction
      if (force_a || (match_a && !hold_a)) begin
        compare_output_a_out <= out_next(output_mode_a, compare_output_a_out, pwm_mode,
          !count_down);
      end else if (pwm_mode && !phase_mode && tick && at_top && output_mode_a[1]) begin
        compare_output_a_out <= !output_mode_a[0];
      end
    end
  end

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      compare_output_b_out <= 1'b0;
    end else begin
      if (force_b || (match_b && !hold_b)) begin
        compare_output_b_out <= out_next(output_mode_b, compare_output_b_out, pwm_mode,
          !count_down);
      end else if (pwm_mode && !phase_mode && tick && at_top && output_mode_b[1]) begin
        compare_output_b_out <= !output_mode_b[0];
      end
    end
  end

  // pin connect lags the mode bits by one cycle, like the level
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      compare_output_a_en_out <= 1'b0;
      compare_output_b_en_out <= 1'b0;
    end else begin
      compare_output_a_en_out <= (output_mode_a != `TMR_COM_OFF);
      compare_output_b_en_out <= (output_mode_b != `TMR_COM_OFF);
    end
  end

  // registered so the request never glitches toward the core
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_request_out <= 3'h0;
    end else begin
      irq_request_out <= timer_interrupt_flags & timer_interrupt_mask
        & {3{global_irq_enable_in}};
    end
  end

  // ****************************************
  // read port
  // ****************************************
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_out <= `TMR_RESET_BYTE;
    end else if (rd_in) begin
      rdata_out <= rd_word;
    end else begin
      rdata_out <= `TMR_RESET_BYTE;
    end
  end

  // decode ahead of the flop so read data stand exactly one cycle
  always @* begin
    rd_word = `TMR_RESET_BYTE;
    case (addr_in)
      `TMR_OFS_CONTROL_A: rd_word = control_a;
      `TMR_OFS_CONTROL_B: rd_word = {4'h0, waveform_mode_bit2, clock_select};
      `TMR_OFS_COUNT: rd_word = timer_count_value;
      `TMR_OFS_COMPARE_A: rd_word = compare_value_a;
      `TMR_OFS_COMPARE_B: rd_word = compare_value_b;
      `TMR_OFS_IRQ_MASK: rd_word = {5'h00, timer_interrupt_mask};
      `TMR_OFS_IRQ_FLAGS: rd_word = {5'h00, timer_interrupt_flags};
      default: rd_word = `TMR_RESET_BYTE;
    endcase
  end
endmodule

// *** tb/tmr_timer8_asserts.sv ***
// Purpose: port-level checker for tmr_timer8
// Assumes: single clock, async active-low reset
// Notes: mask and mode bits mirrored from bus writes
`include "tmr_regs.vh"
module tmr_timer8_asserts (
  input wire clk_in,
  input wire reset_n_in,
  input wire [2:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire global_irq_enable_in,
  input wire [7:0] rdata_out,
  input wire compare_output_a_en_out,
  input wire compare_output_b_en_out,
  input wire [2:0] irq_request_out
);
  reg [2:0] mask;
  reg [3:0] modes;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // mirrors track the design's copies edge for edge
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mask <= 3'h0;
      modes <= 4'h0;
    end else if (wr_in && addr_in == `TMR_OFS_IRQ_MASK) begin
      mask <= wdata_in[2:0];
    end else if (wr_in && addr_in == `TMR_OFS_CONTROL_A) begin
      modes <= wdata_in[7:4];
    end
  end
  sequence s_rd(a);
    rd_in && addr_in == a;
  endsequence
  a_rdata_idle: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data not zero without a read");
  a_force_reads_zero: assert property (s_rd(`TMR_OFS_CONTROL_B) |=> rdata_out[7:4] == 4'h0)
    else $error("control b upper bits not zero");
  a_mask_reserved: assert property (s_rd(`TMR_OFS_IRQ_MASK) |=> rdata_out[7:3] == 5'h00)
    else $error("mask reserved bits not zero");
  a_flags_reserved: assert property (s_rd(`TMR_OFS_IRQ_FLAGS) |=> rdata_out[7:3] == 5'h00)
    else $error("flag reserved bits not zero");
  a_irq_needs_global: assert property (irq_request_out != 3'h0 |-> $past(global_irq_enable_in))
    else $error("irq without global enable");
  a_irq_needs_mask: assert property ((irq_request_out & ~$past(mask)) == 3'h0)
    else $error("irq without its enable bit");
  a_pin_a_connect: assert property (compare_output_a_en_out == ($past(modes[3:2]) != 2'h0))
    else $error("output a enable disagrees with mode");
  a_pin_b_connect: assert property (compare_output_b_en_out == ($past(modes[1:0]) != 2'h0))
    else $error("output b enable disagrees with mode");
endmodule
bind tmr_timer8 tmr_timer8_asserts i_tmr_timer8_asserts (.clk_in, .reset_n_in, .addr_in, .wdata_in, .wr_in,
  .rd_in, .global_irq_enable_in, .rdata_out, .compare_output_a_en_out, .compare_output_b_en_out, .irq_request_out);

// *** tb/tb.sv ***
// Purpose: self-checking bench for tmr_timer8
// Assumes: 20 MHz clock, strobe register port
// Notes: no handshake exists, so waits are fixed counts
`include "tmr_regs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  reg clk_in = 1'b0;
  reg reset_n_in = 1'b0;
  reg [2:0] addr_in = 3'h0;
  reg [7:0] wdata_in = 8'h00;
  reg wr_in = 1'b0;
  reg rd_in = 1'b0;
  reg global_irq_enable_in = 1'b0;
  reg [2:0] vector_ack_in = 3'h0;
  reg external_count_pin_in = 1'b0;
  wire [7:0] rdata_out;
  wire out_a, out_b, en_a, en_b;
  wire [2:0] irq_request_out;
  integer bad_count = 0;
  integer comparisons = 0;
  integer i;
  reg [7:0] r0, r1;
  integer gap [0:5] = '{50, 16, 64, 256, 1024, 4096};
  integer dif [0:5] = '{0, 16, 8, 4, 4, 4};
  reg [1:0] mseq [0:3] = '{2'h1, 2'h2, 2'h3, 2'h1};
  reg eseq [0:3] = '{1'b1, 1'b0, 1'b1, 1'b0};
  always #25 clk_in = ~clk_in;
  tmr_timer8 i_tmr_timer8 (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .global_irq_enable_in(global_irq_enable_in), .vector_ack_in(vector_ack_in),
    .external_count_pin_in(external_count_pin_in), .rdata_out(rdata_out), .compare_output_a_out(out_a),
    .compare_output_b_out(out_b), .compare_output_a_en_out(en_a), .compare_output_b_en_out(en_b),
    .irq_request_out(irq_request_out));
  // ************
  // bus and compare tasks
  // ************
  task chk(input [7:0] got, input [7:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input [2:0] a, input [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task rd(input [2:0] a, output [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  task idle(input integer n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task pin(input v);
    @(posedge clk_in);
    external_count_pin_in <= v;
    idle(8);
  endtask
  task end_sim;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ************
  // scenarios
  // ************
  task t_count;
    rd(`TMR_OFS_CONTROL_B, r0);
    chk(r0, 8'h00);
    wr(`TMR_OFS_COUNT, 8'h5A);
    rd(`TMR_OFS_COUNT, r0);
    chk(r0, 8'h5A);
    // divided ticks counted over whole prescaler periods, phase free
    for (i = 0; i < 6; i = i + 1) begin
      wr(`TMR_OFS_CONTROL_B, i[7:0]);
      rd(`TMR_OFS_COUNT, r0);
      idle(gap[i] - 2);
      rd(`TMR_OFS_COUNT, r1);
      chk(r1 - r0, dif[i][7:0]);
    end
    for (i = 6; i < 8; i = i + 1) begin
      wr(`TMR_OFS_CONTROL_B, i[7:0]);
      rd(`TMR_OFS_COUNT, r0);
      pin(1'b1);
      rd(`TMR_OFS_COUNT, r1);
      chk(r1 - r0, {7'h00, i == 7});
      pin(1'b0);
      rd(`TMR_OFS_COUNT, r1);
      chk(r1 - r0, 8'h01);
    end
  endtask
  task t_flags;
    wr(`TMR_OFS_CONTROL_B, 8'h00);
    wr(`TMR_OFS_IRQ_MASK, 8'h07);
    global_irq_enable_in <= 1'b1;
    wr(`TMR_OFS_COMPARE_A, 8'hF4);
    wr(`TMR_OFS_COMPARE_B, 8'hF8);
    wr(`TMR_OFS_COUNT, 8'hF0);
    wr(`TMR_OFS_CONTROL_B, 8'h01);
    idle(20);
    wr(`TMR_OFS_CONTROL_B, 8'h00);
    rd(`TMR_OFS_IRQ_FLAGS, r0);
    chk(r0, 8'h07);
    chk(irq_request_out, 8'h07);
    wr(`TMR_OFS_IRQ_MASK, 8'hFD);
    rd(`TMR_OFS_IRQ_MASK, r0);
    chk(r0, 8'h05);
    chk(irq_request_out, 8'h05);
    global_irq_enable_in <= 1'b0;
    idle(3);
    chk(irq_request_out, 8'h00);
    wr(`TMR_OFS_IRQ_FLAGS, 8'h02);
    wr(`TMR_OFS_IRQ_FLAGS, 8'h00);
    rd(`TMR_OFS_IRQ_FLAGS, r0);
    chk(r0, 8'h05);
    vector_ack_in <= 3'h1;
    @(posedge clk_in);
    vector_ack_in <= 3'h0;
    rd(`TMR_OFS_IRQ_FLAGS, r0);
    chk(r0, 8'h04);
    wr(`TMR_OFS_IRQ_FLAGS, 8'hFF);
    rd(`TMR_OFS_IRQ_FLAGS, r0);
    chk(r0, 8'h00);
    // a freshly written count must not match on its first tick
    wr(`TMR_OFS_COMPARE_A, 8'h40);
    wr(`TMR_OFS_CONTROL_B, 8'h01);
    wr(`TMR_OFS_COUNT, 8'h40);
    wr(`TMR_OFS_CONTROL_B, 8'h00);
    rd(`TMR_OFS_IRQ_FLAGS, r0);
    chk(r0, 8'h00);
  endtask
  task t_modes;
    // clear-on-match wraps at compare a, so the count never reaches max
    wr(`TMR_OFS_CONTROL_A, 8'h02);
    wr(`TMR_OFS_COMPARE_A, 8'h05);
    wr(`TMR_OFS_COUNT, 8'h00);
    wr(`TMR_OFS_CONTROL_B, 8'h01);
    idle(300);
    wr(`TMR_OFS_CONTROL_B, 8'h00);
    rd(`TMR_OFS_IRQ_FLAGS, r0);
    chk(r0, 8'h02);
    wr(`TMR_OFS_IRQ_FLAGS, 8'h07);
  endtask
  task t_force;
    for (i = 0; i < 4; i = i + 1) begin
      wr(`TMR_OFS_CONTROL_A, {mseq[i], 6'h30});
      wr(`TMR_OFS_CONTROL_B, 8'hC0);
      idle(2);
      chk({out_a, out_b}, {6'h00, eseq[i], 1'b1});
    end
    rd(`TMR_OFS_CONTROL_B, r0);
    chk(r0, 8'h00);
    rd(`TMR_OFS_IRQ_FLAGS, r0);
    chk(r0, 8'h00);
    wr(`TMR_OFS_CONTROL_A, 8'hF1);
    wr(`TMR_OFS_CONTROL_B, 8'hC0);
    idle(2);
    chk(out_a, 8'h00);
    wr(`TMR_OFS_CONTROL_B, 8'h00);
    wr(`TMR_OFS_CONTROL_A, 8'h00);
    idle(2);
    chk({en_a, en_b}, 8'h00);
  endtask
  initial begin
    idle(3);
    reset_n_in <= 1'b1;
    t_count;
    t_flags;
    t_modes;
    t_force;
    end_sim;
  end
  // hang guard, well beyond the planned run
  initial begin
    #2000000;
    bad_count = bad_count + 1;
    end_sim;
  end
endmodule
